// ==== design/touch_scan_pkg.sv ====
// Shared constants and types for the touch scan power and mode controller.
// Assumes a 10 MHz system clock.
package touch_scan_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int NBTN = 10;
	localparam int FEW_BTN_LIMIT = 5;
	localparam int BASE_FAST_MS = 25;
	localparam int BASE_MID_MS = 35;
	localparam int BASE_SLOW_MS = 55;
	localparam int PERIOD_MIN_MS = 25;
	localparam int PERIOD_MAX_MS = 561;
	localparam int WAKE_NORMAL_MS = 20;
	localparam int WAKE_HIGH_MS = 50;
	localparam int SCAN_TIME_CYC = 16;
	localparam int DEBOUNCE_MIN = 1;
	localparam int DEBOUNCE_MAX = 255;
	localparam logic [2:0] MODE_OPERATING = 3'h0;
	localparam logic [2:0] MODE_LED_CFG = 3'h1;
	localparam logic [2:0] MODE_DEV_CFG = 3'h2;
	localparam logic [2:0] MODE_LINE_TEST = 3'h3;
	localparam logic [2:0] MODE_DEBUG = 3'h4;
	localparam logic [2:0] MODE_RESET = 3'h0;

	typedef enum logic [2:0]
	{
		REGMODE_OPERATING,
		REGMODE_LED_CFG,
		REGMODE_DEV_CFG,
		REGMODE_LINE_TEST,
		REGMODE_DEBUG
	} regmode_t;

	typedef struct packed
	{
		logic response_opt;
		logic high_noise;
		logic [3:0] button_count;
		logic [9:0] period_offset_ms;
	} scan_cfg_t;

	typedef struct packed
	{
		logic write_ctrl;
		logic write_gpo;
		logic write_sleep;
		logic write_reset;
		logic write_mode;
		logic write_debug_sel;
		logic read_status;
		logic read_checksum;
		logic read_ident;
		logic read_diag;
		logic read_debug_data;
		logic led_cfg;
		logic dev_cfg;
	} access_t;
endpackage

// ==== design/touch_scan_power_mode_control.sv ====
// Scan, sleep, deep-sleep handshake, debounce and register-mode control.
// Assumes scan results arrive as a strobe with per-button touch levels,
// and the attention/sleep line enters from a pin.
// Functional notes
// [RULE1] Repeat scan then sleep each period
// [RULE2] Period is base plus offset, clamped
// [RULE3] Base constant from count, optimisation, noise
// [RULE4] Host lowers line, sets bit, waits, raises
// [RULE5] Deep sleep stops every scan
// [RULE6] Deep-sleep bit self-clears on entry
// [RULE7] Line low wakes device from deep sleep
// [RULE8] Wake re-initialises, touches suppressed meanwhile
// [RULE9] Host sets deep-sleep bit by bus write
// [RULE10] Normal noise debounce count formula
// [RULE11] High noise requires full debounce count
// [RULE12] Debounce one to 255 every input
// [RULE13] Five register modes, mode change everywhere
// [RULE14] Operating mode access set
// [RULE15] LED configuration mode settings
// [RULE16] Device configuration mode settings
// [RULE17] Host returns to operating mode after
// [RULE18] Line test mode access set
// [RULE19] Debug mode selects parameter and button
// [RULE20] Line low before any transaction
// [RULE21] Unknown mode code keeps current mode
// [RULE22] Counter clears on untouched scan
`timescale 1ns/10ps
module touch_scan_power_mode_control #(
	parameter int NBTN = touch_scan_pkg::NBTN,
	parameter int WAKE_NORMAL_CYC = touch_scan_pkg::WAKE_NORMAL_MS * touch_scan_pkg::CYC_PER_MS,
	parameter int WAKE_HIGH_CYC = touch_scan_pkg::WAKE_HIGH_MS * touch_scan_pkg::CYC_PER_MS,
	parameter int CYC_PER_MS = touch_scan_pkg::CYC_PER_MS
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire touch_scan_pkg::scan_cfg_t scan_cfg,
	input wire logic [NBTN*8-1:0] debounce,
	input wire logic sleep_line_in,
	input wire logic sleep_set,
	input wire logic mode_write,
	input wire logic [2:0] mode_code,
	input wire logic scan_done,
	input wire logic [NBTN-1:0] scan_touch,
	output logic scan_start,
	output logic sleeping,
	output logic deep_sleep,
	output logic sleep_request,
	output logic reinit,
	output logic [NBTN-1:0] touch_valid,
	output logic [9:0] period_ms,
	output logic [5:0] base_ms,
	output touch_scan_pkg::regmode_t reg_mode,
	output touch_scan_pkg::access_t access
);
	typedef enum logic [2:0]
	{
		ST_SCAN,
		ST_SLEEP,
		ST_DEEP_WAIT,
		ST_DEEP,
		ST_WAKE
	} pstate_t;

	pstate_t state;
	logic line_meta;
	logic line_sync;
	logic line_prev;
	logic [23:0] tick;
	logic [9:0] ms_count;
	logic [31:0] wake_cnt;
	logic [31:0] wake_len;
	logic [10:0] sum_ms;
	logic [NBTN-1:0] first_done;

	// Pin synchroniser
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			line_meta <= 1'b1;
			line_sync <= 1'b1;
			line_prev <= 1'b1;
		end
		else
		begin
			line_meta <= sleep_line_in;
			line_sync <= line_meta;
			line_prev <= line_sync;
		end
	end

	// [RULE3] Base constant select
	always_comb
	begin
		if (scan_cfg.button_count <= 4'(touch_scan_pkg::FEW_BTN_LIMIT) && scan_cfg.response_opt)
			base_ms = scan_cfg.high_noise ? 6'(touch_scan_pkg::BASE_MID_MS)
				: 6'(touch_scan_pkg::BASE_FAST_MS);
		else
			base_ms = scan_cfg.high_noise ? 6'(touch_scan_pkg::BASE_SLOW_MS)
				: 6'(touch_scan_pkg::BASE_MID_MS);
	end

	// [RULE2] Period sum and clamp
	always_comb
	begin
		sum_ms = 11'(base_ms) + 11'(scan_cfg.period_offset_ms);
		if (sum_ms > 11'(touch_scan_pkg::PERIOD_MAX_MS))
			period_ms = 10'(touch_scan_pkg::PERIOD_MAX_MS);
		else if (sum_ms < 11'(touch_scan_pkg::PERIOD_MIN_MS))
			period_ms = 10'(touch_scan_pkg::PERIOD_MIN_MS);
		else
			period_ms = sum_ms[9:0];
	end

	assign wake_len = scan_cfg.high_noise ? 32'(WAKE_HIGH_CYC) : 32'(WAKE_NORMAL_CYC);

	// [RULE6] Request bit, set wins over clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sleep_request <= 1'b0;
		else if (sleep_set)
			sleep_request <= 1'b1;
		else if (state == ST_DEEP)
			sleep_request <= 1'b0;
	end

	// [RULE1] Scan-sleep cycle and deep sleep flow
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_SCAN;
			tick <= '0;
			ms_count <= '0;
			wake_cnt <= '0;
		end
		else
		begin
			if (state == ST_SCAN || state == ST_SLEEP)
			begin
				if (tick == 24'(CYC_PER_MS - 1))
				begin
					tick <= '0;
					ms_count <= ms_count + 10'h001;
				end
				else
					tick <= tick + 24'h000001;
			end
			case (state)
				ST_SCAN:
				begin
					if (scan_done)
						state <= ST_SLEEP;
				end
				ST_SLEEP:
				begin
					if (ms_count >= period_ms - 10'h001 && tick == 24'(CYC_PER_MS - 1))
					begin
						ms_count <= '0;
						tick <= '0;
						// [RULE4] At period end a pending request goes to deep wait
						state <= sleep_request ? ST_DEEP_WAIT : ST_SCAN;
					end
				end
				ST_DEEP_WAIT:
				begin
					// [RULE20] Enter only once line released high
					if (line_sync)
						state <= ST_DEEP;
				end
				ST_DEEP:
				begin
					// [RULE7] Falling line wakes
					if (!line_sync && line_prev)
					begin
						state <= ST_WAKE;
						wake_cnt <= '0;
					end
				end
				ST_WAKE:
				begin
					// [RULE8] Re-initialisation time
					if (wake_cnt >= wake_len - 32'h1)
						state <= ST_SCAN;
					else
						wake_cnt <= wake_cnt + 32'h1;
				end
				default:
					state <= ST_SCAN;
			endcase
		end
	end

	// [RULE5] No scans in deep sleep
	always_comb
	begin
		scan_start = (state == ST_SCAN) && ms_count == 10'h000 && tick == 24'h000000;
		sleeping = (state == ST_SLEEP);
		deep_sleep = (state == ST_DEEP) || (state == ST_DEEP_WAIT);
		reinit = (state == ST_WAKE);
	end

	// Per-button debounce
	genvar g;
	generate
		for (g = 0; g < NBTN; g++)
		begin : btn
			logic [7:0] cnt;
			logic [7:0] need;
			logic [7:0] db;
			always_comb
			begin
				// [RULE12] Debounce zero treated as one
				db = (debounce[g*8 +: 8] == 8'h00) ? 8'(touch_scan_pkg::DEBOUNCE_MIN)
					: debounce[g*8 +: 8];
				// [RULE10] Normal noise scan count
				if (!scan_cfg.high_noise)
					need = 8'((db - 8'h01) / 8'h03) + 8'h01 + (first_done[g] ? 8'h00 : 8'h01);
				// [RULE11] High noise scan count
				else
					need = (db == 8'(touch_scan_pkg::DEBOUNCE_MAX) && !first_done[g]) ? 8'hff
						: db + (first_done[g] ? 8'h00 : 8'h01);
			end
			// [RULE22] Consecutive touched scans
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					cnt <= '0;
					touch_valid[g] <= 1'b0;
					first_done[g] <= 1'b0;
				end
				else if (state == ST_WAKE || deep_sleep)
				begin
					cnt <= '0;
					touch_valid[g] <= 1'b0;
				end
				else if (scan_done && state == ST_SCAN)
				begin
					if (!scan_touch[g])
					begin
						cnt <= '0;
						touch_valid[g] <= 1'b0;
					end
					else if (cnt != 8'hff)
					begin
						cnt <= cnt + 8'h01;
						if (cnt + 8'h01 >= need)
						begin
							touch_valid[g] <= 1'b1;
							first_done[g] <= 1'b1;
						end
					end
				end
			end
			// [RULE8] No touch reported during wake
			chk_wake_no_touch: assert property (@(posedge clk) disable iff (!resetn) // [RULE8]
				$past(state) == ST_WAKE |-> !touch_valid[g])
				else $error("touch reported during wake");
			// [RULE22] Untouched scan clears valid
			chk_release_clears: assert property (@(posedge clk) disable iff (!resetn) // [RULE22]
				scan_done && state == ST_SCAN && !scan_touch[g] |=> !touch_valid[g])
				else $error("valid held after untouched scan");
		end
	endgenerate

	// [RULE21] Mode decode, unknown kept
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_mode <= touch_scan_pkg::REGMODE_OPERATING;
		else if (mode_write)
		begin
			case (mode_code)
				touch_scan_pkg::MODE_OPERATING: reg_mode <= touch_scan_pkg::REGMODE_OPERATING;
				touch_scan_pkg::MODE_LED_CFG: reg_mode <= touch_scan_pkg::REGMODE_LED_CFG;
				touch_scan_pkg::MODE_DEV_CFG: reg_mode <= touch_scan_pkg::REGMODE_DEV_CFG;
				touch_scan_pkg::MODE_LINE_TEST: reg_mode <= touch_scan_pkg::REGMODE_LINE_TEST;
				touch_scan_pkg::MODE_DEBUG: reg_mode <= touch_scan_pkg::REGMODE_DEBUG;
				default: reg_mode <= reg_mode;
			endcase
		end
	end

	// [RULE13] Access set per mode
	always_comb
	begin
		access = '0;
		access.write_mode = 1'b1;
		case (reg_mode)
			touch_scan_pkg::REGMODE_OPERATING:
			begin
				// [RULE14] Operating mode set
				access.write_gpo = 1'b1;
				access.write_sleep = 1'b1;
				access.write_reset = 1'b1;
				access.read_status = 1'b1;
				access.read_checksum = 1'b1;
				access.read_ident = 1'b1;
			end
			// [RULE15] LED configuration set
			touch_scan_pkg::REGMODE_LED_CFG: access.led_cfg = 1'b1;
			// [RULE16] Device configuration set
			touch_scan_pkg::REGMODE_DEV_CFG: access.dev_cfg = 1'b1;
			touch_scan_pkg::REGMODE_LINE_TEST:
			begin
				// [RULE18] Line test set
				access.write_gpo = 1'b1;
				access.read_diag = 1'b1;
				access.read_status = 1'b1;
			end
			touch_scan_pkg::REGMODE_DEBUG:
			begin
				// [RULE19] Debug select and data
				access.write_gpo = 1'b1;
				access.write_debug_sel = 1'b1;
				access.read_debug_data = 1'b1;
				access.read_status = 1'b1;
			end
			default: access.write_mode = 1'b1;
		endcase
		access.write_ctrl = access.write_gpo | access.write_sleep | access.write_reset;
	end

	// [RULE5] No scan in deep sleep
	chk_deep_no_scan: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
		state == ST_DEEP && line_sync |=> state == ST_DEEP && !scan_start)
		else $error("scan started in deep sleep");
	// [RULE6] Bit clears on entry
	chk_request_clear: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
		state == ST_DEEP && !sleep_set |=> !sleep_request)
		else $error("deep-sleep bit not cleared");
	// [RULE2] Period bounds
	chk_period_range: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
		period_ms >= 10'(touch_scan_pkg::PERIOD_MIN_MS)
		&& period_ms <= 10'(touch_scan_pkg::PERIOD_MAX_MS))
		else $error("scan period out of range");
	// [RULE3] Few-button fast base
	chk_base_fast: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
		scan_cfg.button_count <= 4'(touch_scan_pkg::FEW_BTN_LIMIT) && scan_cfg.response_opt
		&& !scan_cfg.high_noise |-> base_ms == 6'(touch_scan_pkg::BASE_FAST_MS))
		else $error("wrong base constant");
	// [RULE7] Falling line wakes within three cycles
	chk_wake_entry: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
		state == ST_DEEP && $fell(sleep_line_in) |-> ##[1:3] state == ST_WAKE)
		else $error("no wake on line low");
	// [RULE1] Sleep follows scan completion
	chk_scan_to_sleep: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
		state == ST_SCAN && scan_done |=> sleeping)
		else $error("no sleep after scan");
	// [RULE21] Unknown code keeps mode
	chk_mode_keep: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
		mode_write && mode_code > 3'h4 |=> $stable(reg_mode))
		else $error("mode changed on unknown code");
	// [RULE13] Mode change always allowed
	chk_mode_write: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
		mode_write && mode_code == touch_scan_pkg::MODE_OPERATING
		|=> reg_mode == touch_scan_pkg::REGMODE_OPERATING && access.write_mode)
		else $error("mode change blocked");
endmodule

// ==== verif/host_model.sv ====
// Host model: drives the attention/sleep line and bus-written control pulses.
// Assumes the bench calls its tasks; outputs change only at rising edges.
`timescale 1ns/10ps
module host_model #(
	parameter int CYC_PER_MS = 2
)
(
	input wire logic clk,
	output logic sleep_line,
	output logic sleep_set,
	output logic mode_write,
	output logic [2:0] mode_code
);
	initial
	begin
		sleep_line = 1'b1;
		sleep_set = 1'b0;
		mode_write = 1'b0;
		mode_code = 3'h0;
	end
	task automatic bus_write(input logic is_mode, input logic [2:0] code);
	begin
		@(posedge clk);
		sleep_line <= 1'b0;
		@(posedge clk);
		mode_write <= is_mode;
		sleep_set <= !is_mode;
		mode_code <= code;
		@(posedge clk);
		mode_write <= 1'b0;
		sleep_set <= 1'b0;
	end
	endtask
	task automatic set_mode(input logic [2:0] code);
	begin
		bus_write(1'b1, code);
		sleep_line <= 1'b1;
	end
	endtask
	task automatic enter_deep();
	begin
		bus_write(1'b0, 3'h0);
		repeat (50 * CYC_PER_MS) @(posedge clk);
		sleep_line <= 1'b1;
	end
	endtask
	task automatic wake();
	begin
		@(posedge clk);
		sleep_line <= 1'b0;
	end
	endtask
	task automatic release_line();
	begin
		@(posedge clk);
		sleep_line <= 1'b1;
	end
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the touch scan power and mode controller.
// Assumes host_model on the control inputs; the bench plays the scan engine.
`timescale 1ns/10ps
module tb_top;
	localparam int CPM = 2;
	logic clk;
	logic resetn;
	touch_scan_pkg::scan_cfg_t scan_cfg;
	logic [79:0] debounce;
	logic scan_done;
	logic [9:0] scan_touch;
	logic sleep_line, sleep_set, mode_write;
	logic [2:0] mode_code;
	logic scan_start, sleeping, deep_sleep, sleep_request, reinit;
	logic [9:0] touch_valid, period_ms;
	logic [5:0] base_ms;
	touch_scan_pkg::regmode_t reg_mode;
	touch_scan_pkg::access_t access;
	int fail_count = 0;
	int checks_done = 0;
	int n, need, b, d;
	logic [2:0] cur;
	logic [9:0] seen;
	logic [2:0] codes [8] = '{3'h4, 3'h7, 3'h3, 3'h5, 3'h2, 3'h6, 3'h1, 3'h0};
	host_model #(.CYC_PER_MS(CPM)) u_host (.clk(clk), .sleep_line(sleep_line),
		.sleep_set(sleep_set), .mode_write(mode_write), .mode_code(mode_code));
	touch_scan_power_mode_control #(.CYC_PER_MS(CPM), .WAKE_NORMAL_CYC(40),
		.WAKE_HIGH_CYC(100)) u_dut (.clk(clk), .resetn(resetn), .scan_cfg(scan_cfg),
		.debounce(debounce), .sleep_line_in(sleep_line), .sleep_set(sleep_set),
		.mode_write(mode_write), .mode_code(mode_code), .scan_done(scan_done),
		.scan_touch(scan_touch), .scan_start(scan_start), .sleeping(sleeping),
		.deep_sleep(deep_sleep), .sleep_request(sleep_request), .reinit(reinit),
		.touch_valid(touch_valid), .period_ms(period_ms), .base_ms(base_ms),
		.reg_mode(reg_mode), .access(access));
	function automatic int exp_base(touch_scan_pkg::scan_cfg_t c);
		if (c.response_opt && c.button_count <= 4'h5)
			return c.high_noise ? touch_scan_pkg::BASE_MID_MS : touch_scan_pkg::BASE_FAST_MS;
		return c.high_noise ? touch_scan_pkg::BASE_SLOW_MS : touch_scan_pkg::BASE_MID_MS;
	endfunction
	function automatic int exp_per(touch_scan_pkg::scan_cfg_t c);
		int s;
		s = exp_base(c) + int'(c.period_offset_ms);
		return (s > touch_scan_pkg::PERIOD_MAX_MS) ? touch_scan_pkg::PERIOD_MAX_MS : s;
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
	begin
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic end_sim();
	begin
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task automatic do_scan(input logic [9:0] t, output int cnt);
	begin
		cnt = 0;
		while (scan_start !== 1'b1 && cnt < 2000)
		begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (scan_start !== 1'b1)
			fail_count++;
		@(posedge clk);
		scan_done <= 1'b1;
		scan_touch <= t;
		@(posedge clk);
		scan_done <= 1'b0;
		@(posedge clk);
		#1;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#6000000;
		fail_count++;
		end_sim();
	end
	initial
	begin
		void'($urandom(32'hd6fa));
		resetn = 1'b0;
		scan_cfg = {1'b1, 1'b0, 4'h3, 10'h000};
		debounce = {10{8'h01}};
		scan_done = 1'b0;
		scan_touch = 10'h000;
		seen = 10'h000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		#1;
		cmp(16'({scan_start, sleep_request, deep_sleep, reg_mode}), 16'h0020);
		do_scan(10'h000, n);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			scan_cfg.response_opt <= 1'($urandom());
			scan_cfg.high_noise <= 1'($urandom());
			scan_cfg.button_count <= 4'($urandom_range(10));
			scan_cfg.period_offset_ms <= (i == 1) ? 10'h3ff : 10'($urandom_range(600));
			if (i == 0)
				scan_cfg <= {1'b1, 1'b0, 4'h5, 10'h000};
			@(posedge clk);
			#1;
			cmp(16'(base_ms), 16'(exp_base(scan_cfg)));
			cmp(16'(period_ms), 16'(exp_per(scan_cfg)));
			do_scan(10'h000, n);
			do_scan(10'h000, n);
			cmp(16'(sleeping), 16'h0001);
			do_scan(10'h000, n);
			cmp(16'(n + 3), 16'(exp_per(scan_cfg) * CPM));
			$display("period case %0d done", i);
		end
		for (int i = 0; i < 6; i++)
		begin
			b = (i == 0) ? 0 : $urandom_range(9);
			d = (i == 0) ? 255 : $urandom_range(7, 1);
			@(posedge clk);
			scan_cfg <= {1'b1, (i == 0) ? 1'b0 : 1'($urandom()), 4'h3, 10'h000};
			debounce <= {10{8'(d)}};
			@(posedge clk);
			#1;
			need = scan_cfg.high_noise ? d : (d - 1) / 3 + 1;
			need = need + (seen[b] ? 0 : 1);
			seen[b] = 1'b1;
			do_scan(10'h000, n);
			for (int k = 1; k <= need + 1; k++)
			begin
				do_scan(10'h001 << b, n);
				cmp(16'(touch_valid), (k < need) ? 16'h0000 : 16'(10'h001 << b));
			end
			cmp(16'(touch_valid), 16'(10'h001 << b));
			do_scan(10'h000, n);
			cmp(16'(touch_valid), 16'h0000);
			$display("debounce case %0d done", i);
		end
		cur = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			u_host.set_mode(codes[i]);
			if (codes[i] < 3'h5)
				cur = codes[i];
			#1;
			cmp(16'(reg_mode), 16'(cur));
			cmp(16'({access.write_mode, access.led_cfg, access.dev_cfg, access.read_diag,
				access.read_debug_data, access.read_ident}), 16'({1'b1, cur == 3'h1,
				cur == 3'h2, cur == 3'h3, cur == 3'h4, cur == 3'h0}));
		end
		$display("mode test done");
		@(posedge clk);
		scan_cfg <= {1'b1, 1'b0, 4'h3, 10'h000};
		u_host.enter_deep();
		repeat (5) @(posedge clk);
		#1;
		cmp(16'({deep_sleep, sleep_request}), 16'h0002);
		n = 0;
		repeat (200)
		begin
			@(posedge clk);
			#1;
			if (scan_start === 1'b1 || deep_sleep !== 1'b1)
				n++;
		end
		cmp(16'(n), 16'h0000);
		u_host.wake();
		n = 0;
		while (reinit !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (reinit === 1'b1 && n < 200)
		begin
			@(posedge clk);
			scan_done <= (n < 30);
			scan_touch <= 10'h3ff;
			#1;
			n++;
		end
		cmp(16'(n), 16'(touch_scan_pkg::WAKE_NORMAL_MS * CPM));
		cmp(16'({deep_sleep, touch_valid}), 16'h0000);
		do_scan(10'h000, n);
		cmp(16'(sleeping), 16'h0001);
		u_host.release_line();
		$display("deep sleep test done");
		end_sim();
	end
endmodule
